// ===== accr_bank.sv
// apb register bank for channel 2/3 input selection and channel 2 calibration
//
// Operation
// - decode channel 2 selector into four routings
// - decode channel 3 selector, reset normal pins
// - config bits 5:3 always read zero
// - offset upper bits fill high offset word
// - offset low byte in bits 15:8
// - gain is 24-bit unsigned, split hi/lo
// - gain high resets 8000h, others zero
`include "accr_regs.svh"
`default_nettype none
module accr_bank (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  output accr_pkg::accr_route_type     chan2_route,
  output accr_pkg::accr_route_type     chan3_route,
  output accr_pkg::accr_cal_type       chan2_cal,
  output logic      [15:0]             chan3_offset_upper_bits
);

  // ********************************************************
  // bus decode
  // ********************************************************

  localparam logic [15:0] CFG_MASK = 16'hffc7; // bits 5:3 fixed
  localparam logic [15:0] LO_MASK  = 16'hff00; // bits 7:0 fixed
  localparam int          NREG     = 7;

  logic              setup_phase;
  logic              access_q;
  logic              wr_go;
  logic              rd_go;
  logic [9:0]        word_idx;
  logic              aligned;
  logic [NREG-1:0]   hit;
  logic              mapped;
  logic [15:0]       wdata16;
  logic              lanes_ok;

  // zero-wait slave: answer comes in the first access cycle
  assign setup_phase = psel && !penable;
  assign wr_go       = access_q && pwrite && mapped && lanes_ok;
  assign rd_go       = setup_phase && !pwrite;
  assign word_idx    = paddr[11:2];
  assign aligned     = (paddr[1:0] == 2'h0);
  assign wdata16     = pwdata[15:0];
  // partial writes would tear a 16-bit word, so both low lanes are required
  assign lanes_ok    = (pstrb[1:0] == 2'h3);

  // index compare used for every register
  function automatic logic idx_is(input logic [9:0] idx, input logic [7:0] target);
    idx_is = (idx == {2'h0, target});
  endfunction : idx_is

  assign hit[0] = aligned && idx_is(word_idx, `ACCR_IDX_CHAN2_INPUT_CONFIG);
  assign hit[1] = aligned && idx_is(word_idx, `ACCR_IDX_CH2_OFS_HI);
  assign hit[2] = aligned && idx_is(word_idx, `ACCR_IDX_CH2_OFS_LO);
  assign hit[3] = aligned && idx_is(word_idx, `ACCR_IDX_CH2_GAIN_HI);
  assign hit[4] = aligned && idx_is(word_idx, `ACCR_IDX_CH2_GAIN_LO);
  assign hit[5] = aligned && idx_is(word_idx, `ACCR_IDX_CHAN3_INPUT_CONFIG);
  assign hit[6] = aligned && idx_is(word_idx, `ACCR_IDX_CH3_OFS_HI);
  assign mapped = |hit;

  // tracks the access phase so each write lands exactly once
  always_ff @(posedge clk) begin
    if (srst) begin
      access_q <= 1'b0;
    end else begin
      access_q <= setup_phase;
    end
  end

  // ********************************************************
  // storage
  // ********************************************************

  logic [15:0] word_val [NREG];

  // reserved writable bits are stored as written; host keeps them zero
  accr_word_reg #(.RESET_VAL(`ACCR_RST_CFG), .WR_MASK(CFG_MASK)) u_chan2_input_config (
    .clk(clk), .srst(srst), .wr_en(wr_go && hit[0]), .wr_data(wdata16), .value(word_val[0]));
  accr_word_reg #(.RESET_VAL(`ACCR_RST_OFS_HI), .WR_MASK(16'hffff)) u_ch2_ofs_hi (
    .clk(clk), .srst(srst), .wr_en(wr_go && hit[1]), .wr_data(wdata16), .value(word_val[1]));
  accr_word_reg #(.RESET_VAL(`ACCR_RST_OFS_LO), .WR_MASK(LO_MASK)) u_ch2_ofs_lo (
    .clk(clk), .srst(srst), .wr_en(wr_go && hit[2]), .wr_data(wdata16), .value(word_val[2]));
  accr_word_reg #(.RESET_VAL(`ACCR_RST_GAIN_HI), .WR_MASK(16'hffff)) u_ch2_gain_hi (
    .clk(clk), .srst(srst), .wr_en(wr_go && hit[3]), .wr_data(wdata16), .value(word_val[3]));
  accr_word_reg #(.RESET_VAL(`ACCR_RST_GAIN_LO), .WR_MASK(LO_MASK)) u_ch2_gain_lo (
    .clk(clk), .srst(srst), .wr_en(wr_go && hit[4]), .wr_data(wdata16), .value(word_val[4]));
  accr_word_reg #(.RESET_VAL(`ACCR_RST_CFG), .WR_MASK(CFG_MASK)) u_chan3_input_config (
    .clk(clk), .srst(srst), .wr_en(wr_go && hit[5]), .wr_data(wdata16), .value(word_val[5]));
  accr_word_reg #(.RESET_VAL(`ACCR_RST_OFS_HI), .WR_MASK(16'hffff)) u_ch3_ofs_hi (
    .clk(clk), .srst(srst), .wr_en(wr_go && hit[6]), .wr_data(wdata16), .value(word_val[6]));

  // ********************************************************
  // read path
  // ********************************************************

  logic [15:0] rd_mux;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  // one-hot select; upper half of the bus word reads zero
  always_comb begin
    rd_mux = 16'h0000;
    for (int i = 0; i < NREG; i++) begin
      if (hit[i]) begin
        rd_mux = rd_mux | word_val[i];
      end
    end
  end

  // response registered in setup so pready is high in the first access cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= rd_go ? {16'h0000, rd_mux} : 32'h0000_0000;
      pready_q  <= setup_phase;
      pslverr_q <= setup_phase && (!mapped || (pwrite && !lanes_ok));
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ********************************************************
  // decoded outputs
  // ********************************************************

  function automatic accr_pkg::accr_route_type decode_sel(input logic [1:0] sel);
    accr_pkg::accr_route_type r;
    r = '0;
    case (accr_pkg::accr_sel_type'(sel))
      accr_pkg::ACCR_SEL_NORMAL:  r.pins_connect = 1'b1;
      accr_pkg::ACCR_SEL_SHORTED: r.inputs_short = 1'b1;
      accr_pkg::ACCR_SEL_TEST_P:  r.test_pos     = 1'b1;
      accr_pkg::ACCR_SEL_TEST_N:  r.test_neg     = 1'b1;
      default:                    r.pins_connect = 1'b1;
    endcase
    return r;
  endfunction : decode_sel

  logic [1:0]                chan2_input_select;
  logic [1:0]                chan3_input_select;
  logic [15:0]               chan2_offset_upper_bits;
  logic [7:0]                chan2_offset_lower_bits;
  logic [15:0]               chan2_gain_upper_bits;
  logic [7:0]                chan2_gain_lower_bits;
  accr_pkg::accr_route_type  route2_q;
  accr_pkg::accr_route_type  route3_q;
  accr_pkg::accr_cal_type    cal2_q;
  logic [15:0]               ofs3_q;

  assign chan2_input_select      = word_val[0][`ACCR_CFG_SEL_MSB:`ACCR_CFG_SEL_LSB];
  assign chan3_input_select      = word_val[5][`ACCR_CFG_SEL_MSB:`ACCR_CFG_SEL_LSB];
  assign chan2_offset_upper_bits = word_val[1];
  assign chan2_offset_lower_bits = word_val[2][`ACCR_LO_DATA_MSB:`ACCR_LO_DATA_LSB];
  assign chan2_gain_upper_bits   = word_val[3];
  assign chan2_gain_lower_bits   = word_val[4][`ACCR_LO_DATA_MSB:`ACCR_LO_DATA_LSB];

  // outputs are flopped so routing switches cleanly one cycle after the write
  always_ff @(posedge clk) begin
    if (srst) begin
      route2_q <= 4'h8;
      route3_q <= 4'h8;
      cal2_q   <= {24'h00_0000, 24'h80_0000};
      ofs3_q   <= 16'h0000;
    end else begin
      route2_q <= decode_sel(chan2_input_select);
      route3_q <= decode_sel(chan3_input_select);
      cal2_q   <= {chan2_offset_upper_bits, chan2_offset_lower_bits,
                   chan2_gain_upper_bits, chan2_gain_lower_bits};
      ofs3_q   <= word_val[6];
    end
  end

  assign chan2_route             = route2_q;
  assign chan3_route             = route3_q;
  assign chan2_cal               = cal2_q;
  assign chan3_offset_upper_bits = ofs3_q;

  // ********************************************************
  // assertions
  // ********************************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_cfg_ro_zero: assert property (word_val[0][5:3] == 3'h0 && word_val[5][5:3] == 3'h0)
    else $error("config read-only bits not zero");
  chk_lo_ro_zero: assert property (word_val[2][7:0] == 8'h00 && word_val[4][7:0] == 8'h00)
    else $error("low cal word reserved byte not zero");
  chk_ro_write_ignored: assert property (wr_go && hit[0] |=> word_val[0][5:3] == 3'h0)
    else $error("write reached read-only config bits");
  chk_sel2_route: assert property (wr_go && hit[0] && pwdata[1:0] == 2'h1
    |=> ##1 chan2_route.inputs_short && !chan2_route.pins_connect)
    else $error("channel 2 shorted selection not routed");
  chk_sel3_route: assert property (wr_go && hit[5] && pwdata[1:0] == 2'h3
    |=> ##1 chan3_route.test_neg)
    else $error("channel 3 negative test selection not routed");
  chk_gain_reset: assert property ($fell(srst) |-> word_val[3] == 16'h8000
    && word_val[4] == 16'h0000 && word_val[1] == 16'h0000)
    else $error("calibration reset values wrong");
  chk_ofs_pack: assert property (wr_go && hit[2] |=> ##1
    chan2_cal.offset[7:0] == $past(pwdata[15:8], 2))
    else $error("offset low byte not packed");
  chk_ofs_hi_pack: assert property (wr_go && hit[1] |=> ##1
    chan2_cal.offset[23:8] == $past(pwdata[15:0], 2))
    else $error("offset high word not packed");
  chk_gain_pack: assert property (wr_go && hit[3] |=> ##1
    chan2_cal.gain[23:8] == $past(pwdata[15:0], 2))
    else $error("gain high word not packed");
  chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a one-cycle answer");

  // ********************************************************
  // routing checks
  // ********************************************************

  // a single routing at a time, or the front end would short two sources
  chk_route2_onehot: assert property ($onehot(chan2_route))
    else $error("channel 2 routing not one-hot");

  // same guard for channel 3
  chk_route3_onehot: assert property ($onehot(chan3_route))
    else $error("channel 3 routing not one-hot");

  // code 00b returns channel 2 to its own pins
  chk_sel2_normal: assert property (wr_go && hit[0] && pwdata[1:0] == 2'h0
    |=> ##1 chan2_route.pins_connect)
    else $error("channel 2 normal selection not routed");

  // code 10b feeds the positive test level
  chk_sel2_test_pos: assert property (wr_go && hit[0] && pwdata[1:0] == 2'h2
    |=> ##1 chan2_route.test_pos)
    else $error("channel 2 positive test selection not routed");

  // code 11b feeds the negative test level
  chk_sel2_test_neg: assert property (wr_go && hit[0] && pwdata[1:0] == 2'h3
    |=> ##1 chan2_route.test_neg)
    else $error("channel 2 negative test selection not routed");

  // code 00b returns channel 3 to its own pins
  chk_sel3_normal: assert property (wr_go && hit[5] && pwdata[1:0] == 2'h0
    |=> ##1 chan3_route.pins_connect)
    else $error("channel 3 normal selection not routed");

  // code 01b shorts the channel 3 converter inputs
  chk_sel3_shorted: assert property (wr_go && hit[5] && pwdata[1:0] == 2'h1
    |=> ##1 chan3_route.inputs_short)
    else $error("channel 3 shorted selection not routed");

  // code 10b feeds channel 3 the positive test level
  chk_sel3_test_pos: assert property (wr_go && hit[5] && pwdata[1:0] == 2'h2
    |=> ##1 chan3_route.test_pos)
    else $error("channel 3 positive test selection not routed");

  // both channels leave reset on their own pins
  chk_route_reset: assert property ($fell(srst)
    |-> chan2_route.pins_connect && chan3_route.pins_connect)
    else $error("routing reset value wrong");

  // ********************************************************
  // calibration and config fixed-field checks
  // ********************************************************

  // fixed low byte survives a write of ones
  chk_lo_write_ignored: assert property (wr_go && hit[2] |=> word_val[2][7:0] == 8'h00)
    else $error("write reached offset low reserved byte");

  // same for the gain low word
  chk_glo_write_ignored: assert property (wr_go && hit[4] |=> word_val[4][7:0] == 8'h00)
    else $error("write reached gain low reserved byte");

  // channel 3 config keeps its fixed field too
  chk_cfg3_write_ignored: assert property (wr_go && hit[5] |=> word_val[5][5:3] == 3'h0)
    else $error("write reached channel 3 read-only bits");

  // gain low byte lands in the bottom of the factor
  chk_gain_lo_pack: assert property (wr_go && hit[4] |=> ##1
    chan2_cal.gain[7:0] == $past(pwdata[15:8], 2))
    else $error("gain low byte not packed");

  // unity gain and zero offset straight out of reset
  chk_cal_reset: assert property ($fell(srst)
    |-> chan2_cal.gain == 24'h80_0000 && chan2_cal.offset == 24'h00_0000)
    else $error("calibration output reset value wrong");

  // the output copy trails the stored high offset word by one cycle
  chk_ofs_hi_follow: assert property (chan2_cal.offset[23:8] == $past(word_val[1]))
    else $error("offset upper bits stale");

  // low offset byte trails its word the same way
  chk_ofs_lo_follow: assert property (chan2_cal.offset[7:0] == $past(word_val[2][15:8]))
    else $error("offset lower bits stale");

  // high gain word trails its storage
  chk_gain_hi_follow: assert property (chan2_cal.gain[23:8] == $past(word_val[3]))
    else $error("gain upper bits stale");

  // low gain byte trails its storage
  chk_gain_lo_follow: assert property (chan2_cal.gain[7:0] == $past(word_val[4][15:8]))
    else $error("gain lower bits stale");

  // ********************************************************
  // coverage of the main scenarios
  // ********************************************************

  cov_write_cfg: cover property (wr_go && hit[0]);
  cov_read_gain: cover property (rd_go && hit[3]);
  cov_unmapped: cover property (pready && pslverr);
  cov_sel3_test_neg: cover property (chan3_route.test_neg);
  cov_gain_lo_write: cover property (wr_go && hit[4]);

endmodule : accr_bank
`default_nettype wire

// ===== accr_pkg.sv
// types shared by the channel calibration register bank
`default_nettype none
package accr_pkg;

  // input selector codes
  typedef enum logic [1:0] {
    ACCR_SEL_NORMAL  = 2'h0,
    ACCR_SEL_SHORTED = 2'h1,
    ACCR_SEL_TEST_P  = 2'h2,
    ACCR_SEL_TEST_N  = 2'h3
  } accr_sel_type;

  // decoded input routing for one channel
  typedef struct packed {
    logic pins_connect;
    logic inputs_short;
    logic test_pos;
    logic test_neg;
  } accr_route_type;

  // calibration values of one channel
  typedef struct packed {
    logic [23:0] offset;
    logic [23:0] gain;
  } accr_cal_type;

endpackage : accr_pkg
`default_nettype wire

// ===== accr_regs.svh
// register offsets, field positions and reset values for the channel cal bank
`ifndef ACCR_REGS_SVH
`define ACCR_REGS_SVH

// printed offsets are word indexes; byte address is four times the index
`define ACCR_IDX_CHAN2_INPUT_CONFIG        8'h13
`define ACCR_IDX_CH2_OFS_HI     8'h14
`define ACCR_IDX_CH2_OFS_LO     8'h15
`define ACCR_IDX_CH2_GAIN_HI    8'h16
`define ACCR_IDX_CH2_GAIN_LO    8'h17
`define ACCR_IDX_CHAN3_INPUT_CONFIG        8'h18
`define ACCR_IDX_CH3_OFS_HI     8'h19

// configuration register fields
`define ACCR_CFG_SEL_LSB        0
`define ACCR_CFG_SEL_MSB        1
`define ACCR_CFG_RSVW_BIT       2
`define ACCR_CFG_RO_LSB         3
`define ACCR_CFG_RO_MSB         5
`define ACCR_CFG_RSVH_LSB       6
`define ACCR_CFG_RSVH_MSB       15

// low calibration words carry data in the upper byte only
`define ACCR_LO_DATA_LSB        8
`define ACCR_LO_DATA_MSB        15

// reset values
`define ACCR_RST_CFG            16'h0000
`define ACCR_RST_OFS_HI         16'h0000
`define ACCR_RST_OFS_LO         16'h0000
`define ACCR_RST_GAIN_HI        16'h8000
`define ACCR_RST_GAIN_LO        16'h0000

`endif

// ===== accr_tb.sv
// self-checking testbench for the channel 2/3 input and calibration register bank
`default_nettype none
`include "accr_regs.svh"
`define CHK(got, exp) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                     clk;
  logic                     srst;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [11:0]              paddr;
  logic [31:0]              pwdata;
  logic [3:0]               pstrb;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  accr_pkg::accr_route_type chan2_route;
  accr_pkg::accr_route_type chan3_route;
  accr_pkg::accr_cal_type   chan2_cal;
  logic [15:0]              chan3_offset_upper_bits;
  int                       fail_count;
  int                       checked;
  logic [31:0]              rd_q;
  logic                     err_q;

  // ****************************************
  // device, clock and watchdog
  // ****************************************
  accr_bank dut (
    .clk                     (clk),
    .srst                    (srst),
    .psel                    (psel),
    .penable                 (penable),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdata                  (pwdata),
    .pstrb                   (pstrb),
    .prdata                  (prdata),
    .pready                  (pready),
    .pslverr                 (pslverr),
    .chan2_route             (chan2_route),
    .chan3_route             (chan3_route),
    .chan2_cal               (chan2_cal),
    .chan3_offset_upper_bits (chan3_offset_upper_bits)
  );

  // 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // the whole run needs well under a thousand cycles
  initial begin
    #50000;
    fail_count++;
    stop_test();
  end

  // ****************************************
  // bus tasks
  // ****************************************
  // outputs are sampled at the edge before the design's updates land
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] data,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {16'h0000, data};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [15:0] data);
    apb(1'b1, idx, data, rd_q, err_q);
    `CHK(err_q, 1'b0)
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [15:0] exp);
    apb(1'b0, idx, 16'h0000, rd_q, err_q);
    `CHK(err_q, 1'b0)
    `CHK(rd_q, {16'h0000, exp})
  endtask : rd_chk

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rd_chk(`ACCR_IDX_CHAN2_INPUT_CONFIG, 16'h0000);
    rd_chk(`ACCR_IDX_CH2_OFS_HI, 16'h0000);
    rd_chk(`ACCR_IDX_CH2_OFS_LO, 16'h0000);
    rd_chk(`ACCR_IDX_CH2_GAIN_HI, 16'h8000);
    rd_chk(`ACCR_IDX_CH2_GAIN_LO, 16'h0000);
    rd_chk(`ACCR_IDX_CHAN3_INPUT_CONFIG, 16'h0000);
    rd_chk(`ACCR_IDX_CH3_OFS_HI, 16'h0000);
    `CHK(chan2_route, 4'h8)
    `CHK(chan3_route, 4'h8)
    `CHK(chan2_cal, {24'h00_0000, 24'h80_0000})
  endtask : t_reset

  // every code on both channels, with ones pushed into the read-only bits
  task automatic t_select();
    for (int c = 0; c < 4; c++) begin
      wr(`ACCR_IDX_CHAN2_INPUT_CONFIG, 16'h0038 | 16'(c));
      wr(`ACCR_IDX_CHAN3_INPUT_CONFIG, 16'h0038 | 16'(3 - c));
      repeat (3) @(posedge clk);
      `CHK(chan2_route, 4'(4'h8 >> c))
      `CHK(chan3_route, 4'(4'h8 >> (3 - c)))
      rd_chk(`ACCR_IDX_CHAN2_INPUT_CONFIG, 16'(c));
      rd_chk(`ACCR_IDX_CHAN3_INPUT_CONFIG, 16'(3 - c));
    end
  endtask : t_select

  // negative offset, so a lost sign bit or swapped byte shows
  task automatic t_offset();
    wr(`ACCR_IDX_CH2_OFS_HI, 16'habcd);
    wr(`ACCR_IDX_CH2_OFS_LO, 16'hefff);
    rd_chk(`ACCR_IDX_CH2_OFS_HI, 16'habcd);
    rd_chk(`ACCR_IDX_CH2_OFS_LO, 16'hef00);
    repeat (3) @(posedge clk);
    `CHK(chan2_cal.offset, 24'hab_cdef)
  endtask : t_offset

  // largest gain below 2.0 in the high word, odd pattern in the low byte
  task automatic t_gain();
    wr(`ACCR_IDX_CH2_GAIN_HI, 16'hffff);
    wr(`ACCR_IDX_CH2_GAIN_LO, 16'h12ff);
    wr(`ACCR_IDX_CH3_OFS_HI, 16'h5a5a);
    rd_chk(`ACCR_IDX_CH2_GAIN_LO, 16'h1200);
    rd_chk(`ACCR_IDX_CH3_OFS_HI, 16'h5a5a);
    repeat (3) @(posedge clk);
    `CHK(chan2_cal.gain, 24'hff_ff12)
    `CHK(chan3_offset_upper_bits, 16'h5a5a)
  endtask : t_gain

  // unmapped word and a partial-strobe write must both be refused
  task automatic t_refuse();
    apb(1'b0, 8'h12, 16'h0000, rd_q, err_q);
    `CHK(err_q, 1'b1)
    `CHK(rd_q, 32'h0000_0000)
    pstrb <= 4'h1;
    apb(1'b1, `ACCR_IDX_CH2_GAIN_HI, 16'h0000, rd_q, err_q);
    `CHK(err_q, 1'b1)
    pstrb <= 4'hf;
    rd_chk(`ACCR_IDX_CH2_GAIN_HI, 16'hffff);
  endtask : t_refuse

  task automatic stop_test();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    fail_count = 0;
    checked = 0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_select();
    t_offset();
    t_gain();
    t_refuse();
    // second reset in mid-run restores unity gain
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    stop_test();
  end
endmodule : testbench
`default_nettype wire

// ===== accr_word_reg.sv
// one 16-bit storage word with write mask and registered read data
`default_nettype none
module accr_word_reg #(
  parameter logic [15:0] RESET_VAL = 16'h0000,
  parameter logic [15:0] WR_MASK   = 16'hffff
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] value
);

  logic [15:0] value_q;
  logic [15:0] value_d;

  // masked bits keep their fixed value whatever is written
  assign value_d = wr_en ? ((wr_data & WR_MASK) | (RESET_VAL & ~WR_MASK)) : value_q;
  assign value   = value_q;

  // storage flop
  always_ff @(posedge clk) begin
    if (srst) begin
      value_q <= RESET_VAL;
    end else begin
      value_q <= value_d;
    end
  end

endmodule : accr_word_reg
`default_nettype wire
